// [hdl/lsi_pkg.sv]
// Purpose: Shared constants for the light sensor interrupt block
// Assumes: Byte-wide register map behind a two-wire serial slave
// Notes:   Reserved bits are masked on write and read as zero

package lsi_pkg;

  // Register pointer values
  localparam logic [4:0] REG_IRQ_CTL = 5'h02;
  localparam logic [4:0] REG_LOW0    = 5'h03;
  localparam logic [4:0] REG_LOW1    = 5'h04;
  localparam logic [4:0] REG_HIGH0   = 5'h05;
  localparam logic [4:0] REG_HIGH1   = 5'h06;
  localparam logic [4:0] REG_GAIN    = 5'h07;

  // Control field positions
  localparam int CTL_HALT_BIT = 6;
  localparam int CTL_MODE_BIT = 4;
  localparam int CTL_PERS_MSB = 3;
  localparam int GAIN_MSB     = 2;

  // Reset values and writable-bit masks
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [2:0] GAIN_RESET  = 3'h0;
  localparam logic [7:0] CTL_WMASK   = 8'h5f;

  // Command byte layout
  localparam int         CMD_BIT     = 7;
  localparam int         TRN_MSB     = 6;
  localparam int         TRN_LSB     = 5;
  localparam logic [1:0] TRN_SPECIAL = 2'h3;

  // Serial framing and persistence count limit
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a; // Arbitrary value
  localparam logic [3:0] BIT_LAST      = 4'h8;
  localparam logic [3:0] PERS_MAX      = 4'hf;

  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WDATA, ST_RDATA, ST_ACK_OUT, ST_ACK_IN
  } lsi_bus_st_t;

endpackage

// [hdl/lsi_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Idle level of every pin is high
// Notes:   First stage is read only by the second

`timescale 1ns/1ps
`default_nettype none

module lsi_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;  // First stage

  // Two stages, reset to idle high
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '1;
      dout   <= '1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // lsi_sync

`default_nettype wire

// [hdl/lsi_persist.sv]
// Purpose: Threshold window compare and persistence filter
// Assumes: done is high for one cycle at each integration end
// Notes:   fire is high for one cycle, one cycle after done

`timescale 1ns/1ps
`default_nettype none

module lsi_persist
  import lsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        en,
  input  wire logic        done,
  input  wire logic [15:0] sample,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  input  wire logic [3:0]  persist,
  output logic             fire
);

  logic       out_rng;  // Sample outside window
  logic [3:0] cnt_r;    // Consecutive out-of-range periods
  logic [3:0] cnt_nxt;  // Saturating increment

  assign out_rng = (sample <= lo) || (sample > hi);
  assign cnt_nxt = (cnt_r == PERS_MAX) ? cnt_r : cnt_r + 4'h1;

  always_ff @(posedge clk) begin
    if (srst || !en) begin
      cnt_r <= 4'h0;
      fire  <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (done) begin
        if (persist == 4'h0) begin
          cnt_r <= 4'h0;
          fire  <= 1'b1;
        end else if (out_rng) begin
          cnt_r <= cnt_nxt;
          fire  <= (cnt_nxt >= persist);
        end else begin
          cnt_r <= 4'h0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !en);

  every_cycle_a: assert property (done && persist == 4'h0 |=> fire)
    else $error("Persist zero did not fire");
  single_out_a: assert property (done && persist == 4'h1 && out_rng |=> fire)
    else $error("Single out-of-range did not fire");
  count_gate_a: assert property (done && out_rng && persist > 4'h1
                                 && cnt_r == 4'h0 |=> !fire)
    else $error("Fired before persistence count");
  inside_clear_a: assert property (done && !out_rng && persist != 4'h0
                                   |=> cnt_r == 4'h0 && !fire)
    else $error("Inside result kept the count");
  low_equal_a: assert property (done && sample == lo && persist == 4'h1
                                |=> fire)
    else $error("Equal to low limit not out of range");
  high_equal_a: assert property (done && sample == hi && sample > lo
                                 && persist == 4'h1 |=> !fire)
    else $error("Equal to high limit counted out of range");

  persist_fire_c: cover property (done && persist == 4'h3 ##[1:40] fire);

endmodule // lsi_persist

`default_nettype wire

// [hdl/lsi_top.sv]
// Purpose: Light sensor threshold interrupt with serial register access
// Assumes: ADC_DONE and CH0_DATA come from logic on MCLK
// Notes:   SCL and SDA are pins and pass two flops first

`timescale 1ns/1ps
`default_nettype none

module lsi_top
  import lsi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  output logic             INT_OUT,
  output logic             INT_OE_N,
  input  wire logic        ADC_DONE,
  input  wire logic [15:0] CH0_DATA,
  output logic             ADC_HALT,
  output logic [2:0]       GAIN_SEL
);

  // Synchronised pins and edge history
  logic [1:0]  pin_s;      // {scl, sda} after sync
  logic        scl;        // Synced clock line
  logic        sda;        // Synced data line
  logic        scl_q_r;    // Previous clock level
  logic        sda_q_r;    // Previous data level
  logic        start_ev;   // Start condition
  logic        stop_ev;    // Stop condition
  logic        scl_rise;   // Clock rising edge
  logic        scl_fall;   // Clock falling edge

  // Serial slave state
  lsi_bus_st_t st_r;       // Slave state
  logic [3:0]  bit_cnt_r;  // Bits seen in byte
  logic [7:0]  sh_r;       // Receive shift
  logic [7:0]  rd_sh_r;    // Transmit shift
  logic        rnw_r;      // Read transfer
  logic        first_r;    // Next byte is first
  logic        nack_r;     // Host refused byte
  logic        sda_oe_n_r; // Data line drive
  logic [4:0]  ptr_r;      // Register pointer

  // Byte events
  logic        byte_done;  // Write byte complete
  logic        cmd_byte;   // Byte is a command
  logic        clr_cmd;    // Special clear command
  logic        wr_en;      // Register write
  logic        rd_load;    // Fetch next read byte
  logic [7:0]  rd_byte;    // Read data mux

  // Register file
  logic [7:0]  ctl_r;      // Interrupt control
  logic [7:0]  lim_r [4];  // Limit bytes
  logic [2:0]  gain_r;     // Gain select
  logic [15:0] low_lim;    // Low threshold
  logic [15:0] high_lim;   // High threshold
  logic        mode_on;    // Level mode selected

  // Interrupt state and outputs
  logic        fire;       // Filter event
  logic        irq_r;      // Latched interrupt
  logic        int_oe_n_r; // Pin drive
  logic        halt_r;     // Stop integration
  logic [2:0]  gain_out_r; // Gain to analog side
  logic        sda_out_r;  // Constant low level
  logic        int_out_r;  // Constant low level

  // Pins pass two flops
  lsi_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk  (MCLK),
    .srst (SRST),
    .din  ({SCL_IN, SDA_IN}),
    .dout (pin_s)
  );

  assign scl = pin_s[1];
  assign sda = pin_s[0];

  // Edge history of synced lines
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // Line conditions
  assign start_ev = scl && scl_q_r && sda_q_r && !sda;
  assign stop_ev  = scl && scl_q_r && !sda_q_r && sda;
  assign scl_rise = scl && !scl_q_r;
  assign scl_fall = !scl && scl_q_r;

  // Byte level decode
  assign byte_done = scl_fall && (st_r == ST_WDATA) && (bit_cnt_r == BIT_LAST);
  // first byte with MSB is command
  assign cmd_byte  = byte_done && first_r && sh_r[CMD_BIT];
  assign clr_cmd   = cmd_byte && (sh_r[TRN_MSB:TRN_LSB] == TRN_SPECIAL);
  assign wr_en     = byte_done && !cmd_byte;
  assign rd_load   = scl_fall && (((st_r == ST_ACK_OUT) && rnw_r)
                                  || ((st_r == ST_ACK_IN) && !nack_r));

  // Serial slave sequencing
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_r       <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h00;
      rd_sh_r    <= 8'h00;
      rnw_r      <= 1'b0;
      first_r    <= 1'b0;
      nack_r     <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_ev) begin
      // Start or repeated start
      st_r       <= ST_ADDR;
      bit_cnt_r  <= 4'h0;
      first_r    <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else if (stop_ev) begin
      st_r       <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (scl_rise) begin
      case (st_r)
        ST_ADDR, ST_WDATA, ST_RDATA: begin
          // Sample and count one bit
          sh_r      <= {sh_r[6:0], sda};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        ST_ACK_IN: begin
          // Host acknowledge bit
          nack_r <= sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        ST_ADDR: begin
          // Address match check
          if (bit_cnt_r == BIT_LAST) begin
            if (sh_r[7:1] == DEV_ADDR) begin
              rnw_r      <= sh_r[0];
              st_r       <= ST_ACK_OUT;
              sda_oe_n_r <= 1'b0;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_WDATA: begin
          // Acknowledge written byte
          if (bit_cnt_r == BIT_LAST) begin
            st_r       <= ST_ACK_OUT;
            first_r    <= 1'b0;
            sda_oe_n_r <= 1'b0;
          end
        end
        ST_ACK_OUT: begin
          // End of our acknowledge
          bit_cnt_r <= 4'h0;
          if (rnw_r) begin
            st_r       <= ST_RDATA;
            sda_oe_n_r <= rd_byte[7];
            rd_sh_r    <= {rd_byte[6:0], 1'b0};
          end else begin
            st_r       <= ST_WDATA;
            sda_oe_n_r <= 1'b1;
          end
        end
        ST_RDATA: begin
          // Shift out or release for ack
          if (bit_cnt_r == BIT_LAST) begin
            st_r       <= ST_ACK_IN;
            sda_oe_n_r <= 1'b1;
          end else begin
            sda_oe_n_r <= rd_sh_r[7];
            rd_sh_r    <= {rd_sh_r[6:0], 1'b0};
          end
        end
        ST_ACK_IN: begin
          // Continue only on acknowledge
          bit_cnt_r <= 4'h0;
          if (nack_r) begin
            st_r <= ST_IDLE;
          end else begin
            st_r       <= ST_RDATA;
            sda_oe_n_r <= rd_byte[7];
            rd_sh_r    <= {rd_byte[6:0], 1'b0};
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pointer load and auto-increment
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ptr_r <= 5'h00;
    end else if (cmd_byte) begin
      ptr_r <= sh_r[4:0];
    end else if (wr_en || rd_load) begin
      ptr_r <= ptr_r + 5'h01;
    end
  end

  // Interrupt control register
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctl_r <= CTL_RESET;
    end else if (wr_en && (ptr_r == REG_IRQ_CTL)) begin
      ctl_r <= sh_r & CTL_WMASK;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lim
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        lim_r[g] <= LIMIT_RESET;
      end else if (wr_en && (ptr_r == REG_LOW0 + 5'(g))) begin
        lim_r[g] <= sh_r;
      end
    end
  end

  assign low_lim  = {lim_r[1], lim_r[0]};
  assign high_lim = {lim_r[3], lim_r[2]};
  assign mode_on  = ctl_r[CTL_MODE_BIT];

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      gain_r <= GAIN_RESET;
    end else if (wr_en && (ptr_r == REG_GAIN)) begin
      gain_r <= sh_r[GAIN_MSB:0];
    end
  end

  // Read data by pointer
  always_comb begin
    case (ptr_r)
      REG_IRQ_CTL: rd_byte = ctl_r;
      REG_LOW0:    rd_byte = lim_r[0];
      REG_LOW1:    rd_byte = lim_r[1];
      REG_HIGH0:   rd_byte = lim_r[2];
      REG_HIGH1:   rd_byte = lim_r[3];
      REG_GAIN:    rd_byte = {5'h00, gain_r};
      default:     rd_byte = 8'h00;
    endcase
  end

  lsi_persist u_persist (
    .clk     (MCLK),
    .srst    (SRST),
    .en      (mode_on),
    .done    (ADC_DONE),
    .sample  (CH0_DATA),
    .lo      (low_lim),
    .hi      (high_lim),
    .persist (ctl_r[CTL_PERS_MSB:0]),
    .fire    (fire)
  );

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      irq_r <= 1'b0;
    end else if (fire && mode_on) begin
      irq_r <= 1'b1;
    end else if (clr_cmd) begin
      irq_r <= 1'b0;
    end
  end

  // Output flops
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      int_oe_n_r <= 1'b1;
      halt_r     <= 1'b0;
      gain_out_r <= GAIN_RESET;
      sda_out_r  <= 1'b0;
      int_out_r  <= 1'b0;
    end else begin
      int_oe_n_r <= !(irq_r && mode_on);
      halt_r     <= irq_r && ctl_r[CTL_HALT_BIT];
      gain_out_r <= gain_r;
      sda_out_r  <= 1'b0;
      int_out_r  <= 1'b0;
    end
  end

  assign SDA_OUT  = sda_out_r;
  assign SDA_OE_N = sda_oe_n_r;
  assign INT_OUT  = int_out_r;
  assign INT_OE_N = int_oe_n_r;
  assign ADC_HALT = halt_r;
  assign GAIN_SEL = gain_out_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  pin_open_drain_a: assert property (!INT_OE_N |-> INT_OUT == 1'b0
                                     && $past(irq_r) && $past(mode_on))
    else $error("Interrupt pin driven without cause");
  mode_off_a: assert property (!mode_on ##1 !mode_on |-> INT_OE_N)
    else $error("Pin active with mode off");
  irq_raise_a: assert property (fire && mode_on |=> irq_r ##1 !INT_OE_N
                                || !mode_on)
    else $error("Filter event did not raise pin");
  irq_hold_a: assert property (irq_r && !clr_cmd |=> irq_r)
    else $error("Interrupt dropped without clear");
  irq_clear_a: assert property (clr_cmd && !(fire && mode_on) |=> !irq_r)
    else $error("Clear command ignored");
  halt_follow_a: assert property (irq_r && ctl_r[CTL_HALT_BIT]
                                  |=> ADC_HALT)
    else $error("Integration not halted");
  cmd_no_write_a: assert property (cmd_byte |=> $stable(low_lim)
                                   && $stable(high_lim))
    else $error("Command byte written as limit");
  gain_path_a: assert property (wr_en && ptr_r == REG_GAIN |=> ##1
                                GAIN_SEL == $past(sh_r[GAIN_MSB:0], 2))
    else $error("Gain write not applied");

  irq_set_c: cover property (fire && mode_on ##1 irq_r);
  irq_clr_c: cover property (irq_r ##1 clr_cmd ##1 !irq_r);
  read_c: cover property (rd_load && rnw_r);
  halt_c: cover property ($rose(ADC_HALT));

endmodule // lsi_top

`default_nettype wire

// [bench/lsi_host.sv]
// Purpose: Host model on the two-wire serial register bus
// Assumes: Pull-up on SDA; each SCL phase lasts HALF MCLK cycles
// Notes:   Tasks are called from the bench by hierarchy

`timescale 1ns/1ps
`default_nettype none

module lsi_host
  import lsi_pkg::*;
(
  input  wire logic clk,    // Bench clock, paces the bus
  input  wire logic sda_in, // Resolved SDA wire level
  output logic      scl,    // Serial clock, idles high
  output logic      sda     // SDA drive, 1 releases
);
  localparam int HALF = 6; // Phase length, above the 4-cycle floor

  // Bus idles released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Wait n falling edges
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit; SDA moves a cycle after SCL falls, so no false start
  task automatic bit_io(input logic b, output logic r);
    hw(1);
    sda = b;
    hw(HALF - 1);
    scl = 1'b1;
    hw(HALF / 2);
    r = sda_in;
    hw(HALF / 2);
    scl = 1'b0;
  endtask

  // Start or repeated start
  task automatic start();
    hw(1);
    sda = 1'b1;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda = 1'b0;
    hw(HALF);
    scl = 1'b0;
  endtask

  // Stop, bus left released
  task automatic stop();
    hw(1);
    sda = 1'b0;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda = 1'b1;
    hw(HALF);
  endtask

  // Byte out, slave ack returned
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, host acks unless last
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask

  // Write: address, command, then n data bytes low first
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input int n,
                    input logic [15:0] d, output logic ok);
    logic k;
    start();
    byte_w({a, 1'b0}, ok);
    if (ok) begin
      byte_w(cmd, k);
      ok &= k;
      for (int i = 0; i < n; i++) begin
        byte_w(d[8*i +: 8], k);
        ok &= k;
      end
    end
    stop();
  endtask

  // Read two bytes from the current pointer
  task automatic rd_cur(output logic [15:0] d);
    logic k;
    start();
    byte_w({DEV_ADDR_DFLT, 1'b1}, k);
    byte_r(1'b0, d[7:0]);
    byte_r(1'b1, d[15:8]);
    stop();
  endtask

  // Command byte, then repeated start and read
  task automatic rd_rs(input logic [7:0] cmd, output logic [15:0] d);
    logic k;
    start();
    byte_w({DEV_ADDR_DFLT, 1'b0}, k);
    byte_w(cmd, k);
    rd_cur(d);
  endtask

  // Send command byte, then read
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic k;
    wr(DEV_ADDR_DFLT, cmd, 0, 16'h0000, k);
    rd_cur(d);
  endtask
endmodule // lsi_host

`default_nettype wire

// [bench/lsi_tb_top.sv]
// Purpose: Self-checking bench for the light sensor interrupt block
// Assumes: Host model on SCL/SDA, pull-ups on SDA and interrupt pin
// Notes:   ADC inputs change on the falling edge of MCLK

`timescale 1ns/1ps
`default_nettype none

module lsi_tb_top
  import lsi_pkg::*;
;
  logic        mclk = 1'b0;     // 25 MHz clock
  logic        srst = 1'b1;     // Sync reset
  logic        adc_done = 1'b0; // End of integration
  logic [15:0] ch0 = 16'h0000;  // Channel 0 result
  logic        scl;             // Host serial clock
  logic        sda_drv;         // Host SDA drive
  logic        sda_w;           // Resolved SDA wire
  logic        int_w;           // Resolved interrupt wire
  logic        sda_out;         // Design SDA level
  logic        sda_oe_n;        // Design SDA enable
  logic        int_out;         // Design interrupt level
  logic        int_oe_n;        // Design interrupt enable
  logic        adc_halt;        // Integration stop
  logic [2:0]  gain_sel;        // Gain field
  int          fails = 0;       // Mismatches
  int          check_count = 0; // Comparisons

  always #20 mclk = ~mclk;

  // Open-drain wires with pull-ups
  assign sda_w = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  assign int_w = int_oe_n ? 1'b1 : int_out;

  lsi_top #(.DEV_ADDR(DEV_ADDR_DFLT)) uut (
    .MCLK(mclk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .INT_OUT(int_out),
    .INT_OE_N(int_oe_n), .ADC_DONE(adc_done), .CH0_DATA(ch0),
    .ADC_HALT(adc_halt), .GAIN_SEL(gain_sel)
  );

  lsi_host host (.clk(mclk), .sda_in(sda_w), .scl(scl), .sda(sda_drv));

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Interrupt wire level
  task automatic pin(input logic exp);
    check("int_pin", {15'h0, int_w}, {15'h0, exp});
  endtask

  // Register write, ack expected
  task automatic wreg(input logic [4:0] p, input int n, input logic [15:0] d);
    logic ok;
    host.wr(DEV_ADDR_DFLT, {3'b100, p}, n, d, ok);
    check("write_ack", {15'h0, ok}, 16'h0001);
  endtask

  // Read the byte pair at p and p+1
  task automatic rreg(input logic [4:0] p, output logic [15:0] d);
    host.rd({3'b100, p}, d);
  endtask

  // Clear command, transaction 11
  task automatic clr();
    logic ok;
    host.wr(DEV_ADDR_DFLT, {1'b1, TRN_SPECIAL, 5'h00}, 0, 16'h0000, ok);
  endtask

  // One conversion; data is junk outside the strobe
  task automatic conv(input logic [15:0] d);
    @(negedge mclk);
    adc_done = 1'b1;
    ch0 = d;
    @(negedge mclk);
    adc_done = 1'b0;
    ch0 = ~d;
    repeat (4) @(negedge mclk);
  endtask

  task automatic t_reset();
    logic [15:0] d;
    rreg(REG_IRQ_CTL, d);
    check("ctl_low0", d, 16'h0000);
    rreg(REG_LOW1, d);
    check("low1_high0", d, 16'h0000);
    rreg(REG_HIGH1, d);
    check("high1_gain", d, 16'h0000);
    check("gain_pin", {13'h0, gain_sel}, 16'h0000);
    pin(1'b1);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [15:0] d;
    logic        ok;
    wreg(REG_LOW0, 2, 16'h1234);
    wreg(REG_HIGH0, 2, 16'h5678);
    rreg(REG_LOW0, d);
    check("low_limit", d, 16'h1234);
    rreg(REG_HIGH0, d);
    check("high_limit", d, 16'h5678);
    host.wr(DEV_ADDR_DFLT, {3'b100, REG_HIGH0}, 0, 16'h0000, ok);
    host.rd_cur(d);
    check("send_byte", d, 16'h5678);
    check("gain_pin", {13'h0, gain_sel}, 16'h0000);
    host.rd_rs({3'b100, REG_LOW0}, d);
    check("rep_start", d, 16'h1234);
    wreg(REG_IRQ_CTL, 1, 16'h00ff);
    rreg(REG_IRQ_CTL, d);
    check("ctl_mask", d, 16'h345f);
    wreg(REG_IRQ_CTL, 1, 16'h0000);
    for (int g = 0; g < 4; g++) begin
      wreg(REG_GAIN, 1, 16'h00f8 | 16'(g));
      check("gain_pin", {13'h0, gain_sel}, 16'(g));
    end
    rreg(REG_HIGH1, d);
    check("gain_reg", d, 16'h0356);
    host.wr(DEV_ADDR_DFLT ^ 7'h01, {3'b100, REG_GAIN}, 1, 16'h0000, ok);
    check("foreign_ack", {15'h0, ok}, 16'h0000);
    check("gain_pin", {13'h0, gain_sel}, 16'h0003);
    host.wr(DEV_ADDR_DFLT, 8'h90, 1, 16'h00aa, ok);
    rreg(5'h10, d);
    check("unmapped", d, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_window();
    logic [15:0] vals [6] = '{16'h1001, 16'h2000, 16'h1000, 16'h2001, 16'h0000, 16'hffff};
    logic        hit  [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    wreg(REG_LOW0, 2, 16'h1000);
    wreg(REG_HIGH0, 2, 16'h2000);
    wreg(REG_IRQ_CTL, 1, 16'h0011);
    for (int i = 0; i < 6; i++) begin
      conv(vals[i]);
      pin(~hit[i]);
      if (hit[i]) begin
        check("int_drive", {15'h0, int_out}, 16'h0000);
        conv(16'h1800);
        pin(1'b0);
        clr();
        pin(1'b1);
      end
    end
    // Mode off releases a pending interrupt and blocks new ones
    conv(16'h0000);
    pin(1'b0);
    wreg(REG_IRQ_CTL, 1, 16'h0001);
    pin(1'b1);
    conv(16'h0000);
    pin(1'b1);
    clr();
    $display("test window done");
  endtask

  task automatic t_persist();
    int ns [3] = '{2, 3, 15};
    wreg(REG_IRQ_CTL, 1, 16'h0010);
    conv(16'h1800);
    pin(1'b0);
    clr();
    foreach (ns[j]) begin
      wreg(REG_IRQ_CTL, 1, 16'h0010 | 16'(ns[j]));
      conv(16'h1800);
      clr();
      for (int k = 1; k < ns[j]; k++) begin
        conv(16'h3000);
      end
      pin(1'b1);
      conv(16'h1800);
      for (int k = 1; k < ns[j]; k++) begin
        conv(16'h0800);
      end
      pin(1'b1);
      conv(16'h0800);
      pin(1'b0);
      conv(16'h1800);
      clr();
    end
    $display("test persist done");
  endtask

  task automatic t_halt();
    wreg(REG_IRQ_CTL, 1, 16'h0051);
    conv(16'h0000);
    check("halt", {15'h0, adc_halt}, 16'h0001);
    // clear between halt enable on and off
    clr();
    check("halt", {15'h0, adc_halt}, 16'h0000);
    wreg(REG_IRQ_CTL, 1, 16'h0011);
    conv(16'h0000);
    check("halt", {15'h0, adc_halt}, 16'h0000);
    clr();
    $display("test halt done");
  endtask

  // Counts, verdict, end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after 10 reset cycles
  initial begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset();
    t_regs();
    t_window();
    t_persist();
    t_halt();
    tally_and_finish();
  end

  // Watchdog, well past the expected run length
  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule // lsi_tb_top

`default_nettype wire
